// file: inc/synth_serial_defines.vh
// Constants for the synthesizer serial control port
`ifndef SYNTH_SERIAL_DEFINES_VH
`define SYNTH_SERIAL_DEFINES_VH
`define FRAME_BITS 5'h18
`define FRAME_LAST 5'h17
`define FRAME_READ_BIT 23
`define ADDR_HI 22
`define ADDR_LO 16
`define DATA_HI 15
`define READ_START_CNT 5'h08
`define REG_MAIN_CONTROL 7'h00
`define REG_CAL_CLK_DIV 7'h01
`define REG_FIXED_TWO 7'h02
`define REG_ACAL_CMP_DLY 7'h04
`define REG_FIXED_SEVEN 7'h07
`define REG_OSC_OVERRIDE 7'h08
`define REG_REF_PATH 7'h09
`define REG_REF_MULT 7'h0a
`define REG_REF_DIV 7'h0b
`define REG_REF_PREDIV 7'h0c
`define REG_PUMP_ENABLE 7'h0d
`define REG_PUMP_CURRENT 7'h0e
`define REG_OSC_BIAS 7'h13
`define REG_ACAL_START 7'h14
`define REG_PHASE_SEED 7'h28
`define MC_SLEEP_BIT 0
`define MC_RESET_BIT 1
`define MC_SELECTOR_BIT 2
`define MC_CAL_BIT 3
`define MC_LOCK_EN_BIT 13
`define RST_MAIN_CONTROL 16'h0200
`define RST_ZERO 16'h0000
`define SEL_READBACK 1'b0
`define SEL_LOCK 1'b1
`endif

// file: verilog/pin_sync.v
// Two-flip-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module pin_sync #(
   parameter WIDTH = 4
) (
   input wire sys_clk,
   input wire arst_n,
   input wire [WIDTH-1:0] pinIn,
   output reg [WIDTH-1:0] pinOut
);
   reg [WIDTH-1:0] stageOne;
   // First stage feeds only the second stage
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         stageOne <= {WIDTH{1'b0}};
         pinOut <= {WIDTH{1'b0}};
      end else begin
         stageOne <= pinIn;
         pinOut <= stageOne;
      end
   end
endmodule

// file: verilog/synth_serial_control_port.v
// Serial control port, register file and mode logic of an RF synthesizer
`timescale 1ns/100ps
`include "synth_serial_defines.vh"
////////////////////////////////////////////////////////////////////////////////
// Operation
// - Each phase seed write in fractional mode pulses a phase shift request.
// - Power down when chip enable low or sleep bit set; wake when released.
// - Lock enabled and selector one: output pin follows lock state.
// - Selector zero: output pin carries serial readback data.
// - Read frame has flag one and address; data field is ignored.
// - Readback data starts at the ninth serial clock of a read frame.
// - Frame is 24 bits: flag, 7-bit address, 16-bit data.
// - Bit 23 set means read, clear means write.
// - Data sampled on rising serial clock while select low, MSB first.
// - Select rising edge copies data field into the addressed register.
// - Main control write with calibration bit one starts calibration.
module synth_serial_control_port #(
   parameter NUM_REGS = 15
) (
   input wire sys_clk,
   input wire arst_n,
   input wire serialClk,
   input wire serialData,
   input wire frame_select_n,
   input wire chipEnable,
   input wire pllLocked,
   input wire fractionalMode,
   output reg multiplexed_output_pin,
   output reg muxPinEnable,
   output reg sleep_request_bit,
   output reg softResetPulse,
   output reg calStartPulse,
   output reg phaseShiftPulse,
   output reg [15:0] phase_seed,
   output reg [15:0] controlWord
);
   wire [3:0] syncPins;
   wire sclkS;
   wire sdataS;
   wire selS;
   wire ceS;
   reg sclkPrev;
   reg selPrev;
   reg [23:0] shiftReg;
   reg [4:0] bitCount;
   reg readFrame;
   reg [15:0] readShift;
   reg readActive;
   reg [15:0] regFile [0:NUM_REGS-1];
   reg [15:0] readValue;
   reg [3:0] readIndex;
   reg [3:0] writeIndex;
   reg writeHit;
   wire sclkRise;
   wire sclkFall;
   wire selRise;
   wire selFall;
   wire [6:0] frameAddr;
   wire [15:0] frameData;
   wire frameIsRead;
   reg [15:0] next_readValue;
   integer k;

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: serial clock, data, select and chip enable cross two flip-flops first
   pin_sync #(.WIDTH(4)) uSync (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .pinIn({chipEnable, frame_select_n, serialData, serialClk}),
      .pinOut(syncPins)
   );
   assign sclkS = syncPins[0];
   assign sdataS = syncPins[1];
   assign selS = syncPins[2];
   assign ceS = syncPins[3];

   // Edge detection on synchronised serial clock and select
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         sclkPrev <= 1'b0;
         selPrev <= 1'b0; // Matches the synchroniser's reset level, so no false fall follows reset
      end else begin
         sclkPrev <= sclkS;
         selPrev <= selS;
      end
   end
   assign sclkRise = sclkS & ~sclkPrev;
   assign sclkFall = ~sclkS & sclkPrev;
   assign selRise = selS & ~selPrev;
   assign selFall = ~selS & selPrev;

   // Frame fields, after 24 bits have been shifted in
   assign frameIsRead = shiftReg[`FRAME_READ_BIT];
   assign frameAddr = shiftReg[`ADDR_HI:`ADDR_LO];
   assign frameData = shiftReg[`DATA_HI:0];

   ////////////////////////////////////////////////////////////////////////////
   // Map address to storage slot; unmapped addresses hit nothing
   function [4:0] addrSlot;
      input [6:0] a;
      begin
         case (a)
            `REG_MAIN_CONTROL: addrSlot = 5'h10;
            `REG_CAL_CLK_DIV: addrSlot = 5'h11;
            `REG_FIXED_TWO: addrSlot = 5'h12;
            `REG_ACAL_CMP_DLY: addrSlot = 5'h13;
            `REG_FIXED_SEVEN: addrSlot = 5'h14;
            `REG_OSC_OVERRIDE: addrSlot = 5'h15;
            `REG_REF_PATH: addrSlot = 5'h16;
            `REG_REF_MULT: addrSlot = 5'h17;
            `REG_REF_DIV: addrSlot = 5'h18;
            `REG_REF_PREDIV: addrSlot = 5'h19;
            `REG_PUMP_ENABLE: addrSlot = 5'h1a;
            `REG_PUMP_CURRENT: addrSlot = 5'h1b;
            `REG_OSC_BIAS: addrSlot = 5'h1c;
            `REG_ACAL_START: addrSlot = 5'h1d;
            `REG_PHASE_SEED: addrSlot = 5'h1e;
            default: addrSlot = 5'h00;
         endcase
      end
   endfunction

   // Slot lookups for the read address and the committed write address
   wire [4:0] readSlot;
   wire [4:0] writeSlot;
   assign readSlot = addrSlot(shiftReg[6:0]);
   assign writeSlot = addrSlot(frameAddr);

   // Read value for the address held in the shifter's low seven bits
   always @* begin
      next_readValue = `RST_ZERO;
      readIndex = readSlot[3:0];
      writeIndex = writeSlot[3:0];
      writeHit = writeSlot[4];
      if (readSlot[4]) begin
         next_readValue = regFile[readIndex];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Serial shifter and bit counter
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         shiftReg <= 24'h00_0000;
         bitCount <= 5'h00;
         readFrame <= 1'b0;
      end else if (selFall) begin
         bitCount <= 5'h00;
         readFrame <= 1'b0;
      end else if (!selS && sclkRise && bitCount != `FRAME_BITS) begin
         shiftReg <= {shiftReg[22:0], sdataS};
         bitCount <= bitCount + 5'h01;
         if (bitCount == 5'h00) begin
            readFrame <= sdataS;
         end
      end
   end

   // Readback: load after eight clocks, shift on falling edges
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         readShift <= `RST_ZERO;
         readActive <= 1'b0;
      end else if (selS) begin
         readActive <= 1'b0;
      end else if (sclkFall && readFrame && bitCount == `READ_START_CNT) begin
         readShift <= next_readValue;
         readActive <= 1'b1;
      end else if (sclkFall && readActive) begin
         readShift <= {readShift[14:0], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register file: write on select rising edge of a full write frame
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (k = 0; k < NUM_REGS; k = k + 1) begin
            regFile[k] <= `RST_ZERO;
         end
         regFile[0] <= `RST_MAIN_CONTROL;
      end else if (selRise && bitCount == `FRAME_BITS && !frameIsRead && writeHit) begin
         regFile[writeIndex] <= frameData;
      end
   end

   // Event pulses from writes; read frames raise no pulse and leave the register file alone
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         softResetPulse <= 1'b0;
         calStartPulse <= 1'b0;
         phaseShiftPulse <= 1'b0;
      end else begin
         softResetPulse <= 1'b0;
         calStartPulse <= 1'b0;
         phaseShiftPulse <= 1'b0;
         if (selRise && bitCount == `FRAME_BITS && !frameIsRead) begin
            if (frameAddr == `REG_MAIN_CONTROL) begin
               softResetPulse <= frameData[`MC_RESET_BIT];
               calStartPulse <= frameData[`MC_CAL_BIT];
            end
            if (frameAddr == `REG_PHASE_SEED) begin
               phaseShiftPulse <= fractionalMode;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, all registered
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         multiplexed_output_pin <= 1'b0;
         muxPinEnable <= 1'b0;
         sleep_request_bit <= 1'b1;
         phase_seed <= `RST_ZERO;
         controlWord <= `RST_MAIN_CONTROL;
      end else begin
         sleep_request_bit <= ~ceS | regFile[0][`MC_SLEEP_BIT];
         phase_seed <= regFile[14];
         controlWord <= regFile[0];
         if (regFile[0][`MC_SELECTOR_BIT] == `SEL_READBACK) begin
            multiplexed_output_pin <= readActive & readShift[15];
            muxPinEnable <= readActive;
         end else begin
            multiplexed_output_pin <= regFile[0][`MC_LOCK_EN_BIT] & pllLocked;
            muxPinEnable <= regFile[0][`MC_LOCK_EN_BIT];
         end
      end
   end
endmodule

// file: verification/synth_serial_chk.sv
// Assertions on the serial control port outputs
`timescale 1ns/100ps
module synth_serial_chk (
   input wire sys_clk,
   input wire arst_n,
   input wire chipEnable,
   input wire pllLocked,
   input wire fractionalMode,
   input wire frame_select_n,
   input wire multiplexed_output_pin,
   input wire muxPinEnable,
   input wire sleep_request_bit,
   input wire calStartPulse,
   input wire phaseShiftPulse,
   input wire [15:0] controlWord
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////////////////////////
   // Conditions held long enough to pass the pin synchronisers
   sequence lock_steady;
      (controlWord[2] && controlWord[13] && $stable(pllLocked))[*3];
   endsequence
   sequence select_idle;
      (!controlWord[2] && frame_select_n)[*6];
   endsequence
   a_lock_pin_follow: assert property (lock_steady |-> multiplexed_output_pin == pllLocked)
      else $error("output pin does not follow lock");
   a_pin_release: assert property (select_idle |-> !muxPinEnable) else $error("pin driven after frame");
   a_sleep_by_pin: assert property ((!chipEnable)[*5] |-> sleep_request_bit) else $error("pin sleep missed");
   a_sleep_by_bit: assert property (controlWord[0][*2] |-> sleep_request_bit) else $error("bit sleep missed");
   a_wake_up: assert property ((chipEnable && !controlWord[0])[*6] |-> !sleep_request_bit) else $error("no wake");
   a_cal_trigger: assert property (calStartPulse |-> ##[0:2] controlWord[3]) else $error("stray cal");
   a_shift_fractional: assert property (phaseShiftPulse |-> fractionalMode) else $error("stray shift");
   // Commits only follow the select edge, never mid-frame
   a_ctrl_frame_stable: assert property ((!frame_select_n)[*6] |-> $stable(controlWord))
      else $error("control changed in frame");
endmodule
bind synth_serial_control_port synth_serial_chk chk_u (.sys_clk(sys_clk), .arst_n(arst_n),
   .chipEnable(chipEnable), .pllLocked(pllLocked), .fractionalMode(fractionalMode),
   .frame_select_n(frame_select_n), .multiplexed_output_pin(multiplexed_output_pin),
   .muxPinEnable(muxPinEnable), .sleep_request_bit(sleep_request_bit), .calStartPulse(calStartPulse),
   .phaseShiftPulse(phaseShiftPulse), .controlWord(controlWord));

// file: verification/serial_host_model.sv
// Host side of the serial port: sends frames and collects readback
`timescale 1ns/100ps
module serial_host_model (
   input wire logic sys_clk,
   input wire logic readbackPin,
   output logic serialClk,
   output logic serialData,
   output logic frame_select_n
);
   // Idle bus: clock still low, select high
   initial begin
      serialClk = 1'b0;
      serialData = 1'b0;
      frame_select_n = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One 24-bit frame, MSB first; data moves while the clock is low
   task automatic frame(input logic [23:0] word, output logic [15:0] rd);
      int i;
      rd = 16'h0000;
      @(posedge sys_clk);
      #1 frame_select_n = 1'b0;
      for (i = 23; i >= 0; i--) begin
         serialData = word[i];
         #80 serialClk = 1'b1;
         #79;
         // Late sample in the high phase, clear of the synchroniser delay
         if (i < 16) rd = {rd[14:0], readbackPin};
         #1 serialClk = 1'b0;
      end
      #80 frame_select_n = 1'b1;
      serialData = ~serialData; // Released line shows no stale value
      #160;
   endtask
endmodule

// file: verification/testbench.sv
// Self-checking bench for the synthesizer serial control port
`timescale 1ns/100ps
module testbench;
   logic sys_clk = 0, arst_n = 0, chipEnable = 1, pllLocked = 0, fractionalMode = 1;
   wire serialClk, serialData, frame_select_n, pin, pinEn, sleep_request_bit, rstP, calP, shiftP;
   wire [15:0] phaseSeed, controlWord;
   int bad_count = 0, comparisons = 0, cycles = 0, shifts = 0, cals = 0, resets = 0;
   integer seed = 32'h9f18;
   logic [15:0] rd, d;
   logic [6:0] addrs [16] = '{7'h01, 7'h02, 7'h04, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h0c, 7'h0d, 7'h0e,
      7'h13, 7'h14, 7'h28, 7'h03, 7'h7f};
   synth_serial_control_port dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .serialClk(serialClk),
      .serialData(serialData), .frame_select_n(frame_select_n), .chipEnable(chipEnable), .pllLocked(pllLocked),
      .fractionalMode(fractionalMode), .multiplexed_output_pin(pin), .muxPinEnable(pinEn), .sleep_request_bit(sleep_request_bit),
      .softResetPulse(rstP), .calStartPulse(calP), .phaseShiftPulse(shiftP), .phase_seed(phaseSeed),
      .controlWord(controlWord));
   serial_host_model host_u (.sys_clk(sys_clk), .readbackPin(pinEn ? pin : sys_clk), .serialClk(serialClk),
      .serialData(serialData), .frame_select_n(frame_select_n));
   ////////////////////////////////////////////////////////////////////////////////
   // Clock, pulse counters and hang guard
   initial forever #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      shifts <= shifts + shiftP;
      cals <= cals + calP;
      resets <= resets + rstP;
      if (cycles == 20000) begin
         bad_count++;
         complete_run();
      end
   end
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      comparisons++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Unmapped slots sit at the end of the list and read as zero
   function automatic logic [15:0] stored(input int i, input logic [15:0] v);
      return (i < 14) ? v : 16'h0000;
   endfunction
   task automatic wr(input logic [6:0] a, input logic [15:0] v);
      host_u.frame({1'b0, a, v}, rd);
   endtask
   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (4) @(posedge sys_clk);
      #1 arst_n = 1;
      repeat (4) @(posedge sys_clk);
      check("control reset", 16'h0200, controlWord);
      check("seed reset", 16'h0000, phaseSeed);
      wr(7'h00, 16'h0202);
      check("soft resets", 16'(resets), 16'h0001);
      foreach (addrs[i]) begin
         d = 16'($random(seed));
         wr(addrs[i], d);
         host_u.frame({1'b1, addrs[i], 16'($random(seed))}, rd);
         check("readback", stored(i, d), rd);
      end
      check("phase shifts", 16'(shifts), 16'h0001);
      fractionalMode = 0;
      wr(7'h28, 16'h0010);
      check("seed out", 16'h0010, phaseSeed);
      check("integer shifts", 16'(shifts), 16'h0001);
      $display("test registers done");
      wr(7'h00, 16'h0209);
      check("power by bit", 16'(sleep_request_bit), 16'h0001);
      wr(7'h00, 16'h0208);
      check("wake by bit", 16'(sleep_request_bit), 16'h0000);
      check("cal starts", 16'(cals), 16'h0002);
      chipEnable = 0;
      repeat (6) @(posedge sys_clk);
      #1 check("power by pin", 16'(sleep_request_bit), 16'h0001);
      chipEnable = 1;
      wr(7'h00, 16'h0208);
      check("wake by pin", 16'(sleep_request_bit), 16'h0000);
      $display("test power done");
      wr(7'h00, 16'h2204);
      repeat (20) begin
         pllLocked = 1'($random(seed));
         repeat (4) @(posedge sys_clk);
         #1 check("lock pin", 16'({1'b1, pllLocked}), 16'({pinEn, pin}));
      end
      wr(7'h00, 16'h0204);
      check("lock pin off", 16'h0000, 16'({pinEn, pin}));
      $display("test lock done");
      complete_run();
   end
endmodule
